/* src/txc_tx_clock_align.sv */
// Transmit input clock select, phase-align buffer and transmit clock output
//
// Function
// - With half-rate reference clock and select low, inputs are sampled and outputs change on both reference edges.
// - While the phase reset is sampled low, the phase-align buffer readjusts its transfer timing.
// - Once the phase reset is sampled high, the buffer phase is held fixed and operation is normal.
// - In half-rate reference sampling mode, the phase reset only clears buffer faults.
// - Characters may be dropped or inserted while the buffer realigns.
// - With clock select low and rate select low, the buffer is bypassed and phase reset ignored.
// - The input register is clocked by the reference clock on select low, else by the host clock.
// - The transmit clock output runs at reference rate, or twice it when rate select is high.
// - The transmit clock output toggles on every reference edge, so it follows the reference phase.
// - The PLL multiplies the reference by twenty at rate select high and by ten when low.
// - Buffer underflow or overflow raises the error flag until a word sync or a phase reset.
`timescale 1ns/1ps
`default_nettype none
`include "txc_consts.svh"
module txc_tx_clock_align #(
    parameter int DEPTH = `TXC_FIFO_DEPTH,
    parameter int CENTRE = `TXC_FIFO_CENTRE,
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Clocks from outside
    input wire logic reference_clock_i,
    input wire logic host_transmit_clock_i,
    // Static controls and phase reset
    input wire logic [1:0] tx_input_clock_select_i,
    input wire logic tx_pll_rate_select_i,
    input wire logic tx_phase_reset_n_i,
    // Parallel character from the host
    input wire logic [7:0] tx_data_i,
    input wire logic [1:0] tx_char_control_i,
    input wire logic tx_word_sync_i,
    // Character towards encoder or shifter
    output logic [7:0] char_data_o,
    output logic [1:0] char_control_o,
    output logic char_word_sync_o,
    output logic char_valid_o,
    // Clock output, status and PLL setting
    output logic transmit_clock_out_o,
    output logic transmit_clock_out_n_o,
    output logic tx_error_flag_o,
    output logic buffer_bypass_o,
    output logic [4:0] bit_clock_mult_o
);
    import txc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // ==========================================================
    // State
    typedef struct packed {
        txc_char_s [DEPTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] fill;
        txc_char_s in_reg;
        logic in_valid;
        txc_char_s out_char;
        logic out_valid;
        logic [1:0] rst_low_cnt;
        logic err;
        logic tclk;
        logic tclk_n;
        logic [CNT_W-1:0] since_edge;
        logic [CNT_W-1:0] half_len;
        logic bypass;
        logic [4:0] mult;
    } txc_state_s;

    txc_state_s state_q;
    txc_state_s state_d;

    // ==========================================================
    // Synchronisers
    logic ref_rise;
    logic ref_fall;
    logic host_rise;
    logic rst_n_s;
    logic [10:0] pins_s;

    txc_sync #(.WIDTH(1)) u_sync_ref (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(reference_clock_i),
        .sync_o(),
        .rise_o(ref_rise),
        .fall_o(ref_fall)
    );

    txc_sync #(.WIDTH(1)) u_sync_host (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(host_transmit_clock_i),
        .sync_o(),
        .rise_o(host_rise),
        .fall_o()
    );

    txc_sync #(.WIDTH(1)) u_sync_rst (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(tx_phase_reset_n_i),
        .sync_o(rst_n_s),
        .rise_o(),
        .fall_o()
    );

    // Data path delayed like the clocks so edges meet settled data
    txc_sync #(.WIDTH(11)) u_sync_data (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({tx_word_sync_i, tx_char_control_i, tx_data_i}),
        .sync_o(pins_s),
        .rise_o(),
        .fall_o()
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        logic half_rate;
        logic sel_ref;
        logic wr_tick;
        logic char_tick;
        logic realign;
        logic do_wr;
        logic do_rd;
        logic ovf;
        logic unf;
        half_rate = tx_pll_rate_select_i;
        sel_ref = (tx_input_clock_select_i == `TXC_CKSEL_LOW);
        wr_tick = 1'b0;
        char_tick = 1'b0;
        realign = 1'b0;
        do_wr = 1'b0;
        do_rd = 1'b0;
        ovf = 1'b0;
        unf = 1'b0;
        state_d = state_q;
        state_d.bypass = sel_ref && !half_rate;
        state_d.mult = half_rate ? `TXC_MULT_HALF : `TXC_MULT_FULL;
        // Input register clock: reference edges or host clock rise
        if (sel_ref)
            wr_tick = ref_rise || (half_rate && ref_fall);
        else
            wr_tick = host_rise;
        // Character clock from the PLL: one per reference period, two at half rate
        char_tick = ref_rise || (half_rate && ref_fall);
        // Phase reset counted on rising reference edges only
        if (ref_rise)
        begin
            if (rst_n_s)
                state_d.rst_low_cnt = 2'h0;
            else if (state_q.rst_low_cnt != `TXC_RST_EDGES)
                state_d.rst_low_cnt = state_q.rst_low_cnt + 2'h1;
        end
        realign = (state_d.rst_low_cnt == `TXC_RST_EDGES) && !state_d.bypass;
        // Half-rate reference mode uses the reset just to clear a fault
        if (sel_ref && half_rate && !state_q.err)
            realign = 1'b0;
        // Input register capture
        state_d.in_valid = wr_tick;
        if (wr_tick)
            state_d.in_reg = txc_char_s'(pins_s);
        // Buffer traffic
        do_wr = state_q.in_valid && !state_d.bypass;
        do_rd = char_tick && !state_d.bypass;
        ovf = do_wr && (state_q.fill == (AW+1)'(DEPTH)) && !do_rd;
        unf = do_rd && (state_q.fill == '0);
        state_d.out_valid = char_tick;
        if (state_d.bypass)
        begin
            // Straight through on the character clock
            if (char_tick)
                state_d.out_char = state_q.in_reg;
        end
        else if (realign)
        begin
            // Recentre; contents are stale so characters may repeat or vanish
            state_d.rd_ptr = '0;
            state_d.wr_ptr = AW'(CENTRE);
            state_d.fill = (AW+1)'(CENTRE);
        end
        else
        begin
            if (do_rd)
            begin
                state_d.out_char = state_q.mem[state_q.rd_ptr];
                if (!unf)
                    state_d.rd_ptr = AW'((state_q.rd_ptr + 1) % DEPTH);
            end
            if (do_wr && !ovf)
            begin
                state_d.mem[state_q.wr_ptr] = state_q.in_reg;
                state_d.wr_ptr = AW'((state_q.wr_ptr + 1) % DEPTH);
            end
            state_d.fill = state_q.fill + (AW+1)'(do_wr && !ovf) - (AW+1)'(do_rd && !unf);
        end
        // Fault flag: a bypass or realign clear wins over a new fault in the same cycle
        if (state_d.bypass || realign || (do_rd && state_d.out_char.word_sync && !unf))
            state_d.err = 1'b0;
        if (!state_d.bypass && !realign && (ovf || unf))
            state_d.err = 1'b1;
        // Measure reference half period to place the extra toggle
        if (ref_rise || ref_fall)
        begin
            state_d.half_len = state_q.since_edge;
            state_d.since_edge = '0;
        end
        else if (state_q.since_edge != '1)
            state_d.since_edge = state_q.since_edge + CNT_W'(1);
        // Clock out toggles per reference edge, twice as often at half rate
        if (ref_rise || ref_fall)
            state_d.tclk = !state_q.tclk;
        else if (half_rate && state_q.half_len != '0
                 && state_q.since_edge == (state_q.half_len >> 1))
            state_d.tclk = !state_q.tclk;
        // Complement in its own flop so the pin has no gate after it
        state_d.tclk_n = !state_d.tclk;
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= '0;
            state_q.tclk_n <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign char_data_o = state_q.out_char.data;
    assign char_control_o = state_q.out_char.control;
    assign char_word_sync_o = state_q.out_char.word_sync;
    assign char_valid_o = state_q.out_valid;
    assign transmit_clock_out_o = state_q.tclk;
    assign transmit_clock_out_n_o = state_q.tclk_n;
    assign tx_error_flag_o = state_q.err;
    assign buffer_bypass_o = state_q.bypass;
    assign bit_clock_mult_o = state_q.mult;
endmodule
`default_nettype wire

/* src/txc_consts.svh */
// Constants for the transmit clock select and phase-align block
`ifndef TXC_CONSTS_SVH
`define TXC_CONSTS_SVH
// Three-level clock select encodings on the two-bit select port
`define TXC_CKSEL_LOW 2'h0
`define TXC_CKSEL_MID 2'h1
`define TXC_CKSEL_HIGH 2'h2
// Rising reference edges with phase reset low before it takes effect
`define TXC_RST_EDGES 2'h2
// Serial bit clock multipliers of the transmit PLL
`define TXC_MULT_FULL 5'h0a
`define TXC_MULT_HALF 5'h14
// Phase-align buffer depth and its recentred fill
`define TXC_FIFO_DEPTH 4
`define TXC_FIFO_CENTRE 2
`endif

/* src/txc_pkg.sv */
// Types shared by the transmit clock select and phase-align block
package txc_pkg;
    // One transmit character as carried through the phase-align buffer
    typedef struct packed {
        logic word_sync;
        logic [1:0] control;
        logic [7:0] data;
    } txc_char_s;
endpackage

/* src/txc_sync.sv */
// Two-flop synchroniser with edge pulses for pin inputs
`timescale 1ns/1ps
`default_nettype none
module txc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Asynchronous input and synchronised view
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;
    logic [2:0] warm_q;

    // First flop feeds only the second one
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
            warm_q <= 3'h0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
            warm_q <= {warm_q[1:0], 1'b1};
        end
    end

    // Edges judged on settled samples only
    // Pin level is unknown at reset, so edges wait until all three flops hold real samples
    assign sync_o = sync_q;
    assign rise_o = sync_q & ~prev_q & {WIDTH{warm_q[2]}};
    assign fall_o = ~sync_q & prev_q & {WIDTH{warm_q[2]}};
endmodule
`default_nettype wire

/* tb/txc_host_model.sv */
// Host side model: reference and host clocks and a counting character stream
`timescale 1ns/1ps
`default_nettype none
module txc_host_model (
    // Setup from the bench
    input wire logic [1:0] sel_i,
    input wire logic rate_i,
    input wire logic [7:0] host_half_i,
    // Clocks and character towards the block
    output logic ref_clk_o,
    output logic host_clk_o,
    output logic [7:0] data_o
);
    // ==========
    // Free running clocks, 80 ns reference
    initial
    begin
        ref_clk_o = 1'b0;
        forever #40 ref_clk_o = ~ref_clk_o;
    end
    initial
    begin
        host_clk_o = 1'b0;
        forever #(host_half_i) host_clk_o = ~host_clk_o;
    end
    // New character 20 ns after each capture edge, so setup is never marginal
    initial
    begin
        data_o = 8'h00;
        forever
        begin
            if (sel_i != 2'h0)
                @(posedge host_clk_o);
            else if (rate_i)
                @(ref_clk_o);
            else
                @(posedge ref_clk_o);
            #20 data_o = data_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* tb/txc_tx_clock_align_monitor.sv */
// Port checker for the transmit clock select and phase-align block
`timescale 1ns/1ps
`default_nettype none
module txc_tx_clock_align_monitor (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Watched ports
    input wire logic [1:0] tx_input_clock_select_i,
    input wire logic tx_pll_rate_select_i,
    input wire logic tx_phase_reset_n_i,
    input wire logic [7:0] char_data_o,
    input wire logic char_valid_o,
    input wire logic transmit_clock_out_o,
    input wire logic transmit_clock_out_n_o,
    input wire logic tx_error_flag_o,
    input wire logic buffer_bypass_o,
    input wire logic [4:0] bit_clock_mult_o
);
    // ==========
    // Checks, one domain
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_CLK_PAIR: assert property (transmit_clock_out_n_o == ~transmit_clock_out_o)
        else $error("clock out pair not complementary");
    AST_MULT: assert property ($past(rst_n_i) |->
        bit_clock_mult_o == ($past(tx_pll_rate_select_i) ? 5'h14 : 5'h0a))
        else $error("wrong bit clock multiplier");
    AST_BYPASS: assert property ($past(rst_n_i) |->
        buffer_bypass_o == $past(tx_input_clock_select_i == 2'h0 && !tx_pll_rate_select_i))
        else $error("wrong bypass state");
    AST_STAND: assert property ($past(rst_n_i) && !char_valid_o |-> $stable(char_data_o))
        else $error("character changed without valid");
    AST_FULL_TICK: assert property (!tx_pll_rate_select_i && char_valid_o |=> !char_valid_o [*8])
        else $error("character ticks too close at full rate");
    AST_HALF_TICK: assert property (tx_pll_rate_select_i && char_valid_o |-> ##[4:12] char_valid_o)
        else $error("no tick on both reference edges");
    AST_TOGGLE: assert property ($changed(transmit_clock_out_o) |->
        ##[1:12] $changed(transmit_clock_out_o))
        else $error("clock out stopped");
    AST_BYP_ERR: assert property (buffer_bypass_o ##1 buffer_bypass_o |=> !tx_error_flag_o)
        else $error("error flag in bypass");
    AST_REALIGN: assert property (!tx_phase_reset_n_i [*8] ##0 !buffer_bypass_o &&
        !tx_pll_rate_select_i |-> ##[0:60] (!tx_error_flag_o || tx_phase_reset_n_i))
        else $error("phase reset did not clear error");
endmodule
bind txc_tx_clock_align txc_tx_clock_align_monitor u_mon (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .tx_input_clock_select_i(tx_input_clock_select_i),
    .tx_pll_rate_select_i(tx_pll_rate_select_i), .tx_phase_reset_n_i(tx_phase_reset_n_i),
    .char_data_o(char_data_o), .char_valid_o(char_valid_o),
    .transmit_clock_out_o(transmit_clock_out_o), .transmit_clock_out_n_o(transmit_clock_out_n_o),
    .tx_error_flag_o(tx_error_flag_o), .buffer_bypass_o(buffer_bypass_o),
    .bit_clock_mult_o(bit_clock_mult_o)
);
`default_nettype wire

/* tb/txc_tx_clock_align_test.sv */
// Self-checking bench for the transmit clock select and phase-align block
`timescale 1ns/1ps
`default_nettype none
module txc_tx_clock_align_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] sel = 2'h0;
    logic rate = 1'b0;
    logic prst_n = 1'b1;
    logic wsync = 1'b0;
    logic cws;
    logic [7:0] host_half = 8'h28;
    logic ref_clk, host_clk, cvalid, clk_out, err, bypass;
    logic [7:0] hdata, cdata;
    logic [1:0] cctl;
    logic [4:0] mult;
    int n_errors = 0;
    int num_checks = 0;
    // ==========
    // Clock and instances
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    txc_host_model host (.sel_i(sel), .rate_i(rate), .host_half_i(host_half),
        .ref_clk_o(ref_clk), .host_clk_o(host_clk), .data_o(hdata));
    txc_tx_clock_align uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reference_clock_i(ref_clk),
        .host_transmit_clock_i(host_clk), .tx_input_clock_select_i(sel),
        .tx_pll_rate_select_i(rate), .tx_phase_reset_n_i(prst_n), .tx_data_i(hdata),
        .tx_char_control_i(~hdata[1:0]), .tx_word_sync_i(wsync), .char_data_o(cdata),
        .char_control_o(cctl), .char_word_sync_o(cws), .char_valid_o(cvalid),
        .transmit_clock_out_o(clk_out), .transmit_clock_out_n_o(), .tx_error_flag_o(err),
        .buffer_bypass_o(bypass), .bit_clock_mult_o(mult));
    // ==========
    // Shared tasks
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t count %h outside %h..%h", $time, got, lo, hi);
        end
    endtask
    // Bounded wait for the next character; a hang ends the run
    task automatic next_char(output logic [7:0] d);
        int i;
        i = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        while (cvalid !== 1'b1 && i < 100);
        if (cvalid !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t no character", $time);
            summarize();
        end
        else
        begin
            d = cdata;
            check({6'h00, cctl}, {6'h00, ~cdata[1:0]});
        end
    endtask
    task automatic run_seq(input int n);
        logic [7:0] a, b;
        int k;
        next_char(a);
        for (k = 0; k < n; k++)
        begin
            next_char(b);
            check(b, a + 8'h01);
            a = b;
        end
    endtask
    // Clock out toggles over four reference periods
    task automatic clk_rate(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] n;
        logic last;
        int k;
        n = 8'h00;
        last = clk_out;
        for (k = 0; k < 64; k++)
        begin
            @(posedge sys_clk);
            #1;
            if (clk_out !== last)
                n++;
            last = clk_out;
        end
        check_rng(n, lo, hi);
    endtask
    // Static controls change only while the block is held in reset
    task automatic restart(input logic [1:0] s, input logic r);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        sel <= s;
        rate <= r;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (40) @(posedge sys_clk);
    endtask
    // Low for three reference periods, more than two reference rises
    task automatic phase_reset();
        @(posedge sys_clk);
        prst_n <= 1'b0;
        repeat (48) @(posedge sys_clk);
        #1 check({7'h00, err}, 8'h00);
        @(posedge sys_clk);
        prst_n <= 1'b1;
    endtask
    // ==========
    // Scenarios
    task automatic test_bypass();
        restart(2'h0, 1'b0);
        check({7'h00, bypass}, 8'h01);
        check({3'h0, mult}, 8'h0a);
        fork
            phase_reset();
            run_seq(8);
        join
        clk_rate(8'h07, 8'h09);
    endtask
    task automatic test_host();
        logic [7:0] d;
        restart(2'h2, 1'b0);
        phase_reset();
        repeat (4) next_char(d);
        run_seq(8);
        check({6'h00, bypass, err}, 8'h00);
    endtask
    task automatic test_half();
        logic [7:0] d;
        restart(2'h0, 1'b1);
        check({3'h0, mult}, 8'h14);
        phase_reset();
        repeat (4) next_char(d);
        run_seq(8);
        clk_rate(8'h0f, 8'h11);
    endtask
    // Host clock too fast for the character clock fills the buffer
    task automatic test_fault();
        int i;
        host_half <= 8'h1e;
        restart(2'h1, 1'b0);
        for (i = 0; i < 400 && err !== 1'b1; i++)
            @(posedge sys_clk);
        check({7'h00, err}, 8'h01);
        phase_reset();
        // Recentred buffer overflows again, then rates match and the flag must stick
        for (i = 0; i < 400 && err !== 1'b1; i++)
            @(posedge sys_clk);
        host_half <= 8'h28;
        repeat (200) @(posedge sys_clk);
        #1 check({7'h00, err}, 8'h01);
        // A word sync character read out clears the flag
        @(posedge sys_clk);
        wsync <= 1'b1;
        for (i = 0; i < 400 && err !== 1'b0; i++)
            @(posedge sys_clk);
        #1 check({7'h00, err}, 8'h00);
        check({7'h00, cws}, 8'h01);
        @(posedge sys_clk);
        wsync <= 1'b0;
    endtask
    initial
    begin
        test_bypass();
        test_host();
        test_half();
        test_fault();
        summarize();
    end
endmodule
`default_nettype wire
